//--- bench/hspc_power_ctrl_asserts.sv
// checker for the halt and stop power control block
`default_nettype none
module hspc_power_ctrl_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic standbyCtrl,
  input wire logic intReq_n,
  input wire logic opValid,
  input wire logic [7:0] opCode,
  input wire logic instrDone,
  input wire logic coreClkEn,
  input wire logic oscEnable,
  input wire logic stopped,
  input wire logic interrupts_enabled_state,
  input wire logic intVectorReq,
  input wire logic forceResetVector,
  input wire logic halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////
  // halt entry and wake requests
  sequence s_halt;
    opValid && opCode == 8'h01 && coreClkEn && !halted;
  endsequence
  sequence s_wake; halted && !intReq_n; endsequence
  property p_halt; s_halt |=> halted && !coreClkEn; endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_gate; halted |-> !coreClkEn && oscEnable; endproperty
  a_gate: assert property (p_gate) else $error("bad gating");
  property p_hold; halted && intReq_n |=> halted; endproperty
  a_hold: assert property (p_hold) else $error("left halt");
  property p_wake; s_wake |=> !halted && coreClkEn; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_vec;
    $rose(intVectorReq) |-> $past(instrDone, 2) && interrupts_enabled_state;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  // reset and standby levels act during reset
  property p_rst; disable iff (1'b0) !reset_n |=> forceResetVector
    && !halted && !coreClkEn && !interrupts_enabled_state; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_stop;
    disable iff (1'b0) !reset_n && !standbyCtrl |=> stopped && !oscEnable;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_exit;
    disable iff (1'b0) !reset_n && standbyCtrl |=> oscEnable && !stopped;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");
endmodule // hspc_power_ctrl_asserts
bind hspc_power_ctrl hspc_power_ctrl_asserts i_chk (.*);
`default_nettype wire

//--- bench/hspc_power_ctrl_tb.sv
// self-checking bench for the halt and stop power control block
`default_nettype none
module hspc_power_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n, standbyCtrl, intReq_n = 1'b1, opValid = 1'b0;
  logic instrDone = 1'b0, enableIntOp = 1'b0, disableIntOp = 1'b0;
  logic vectorTaken = 1'b0;
  logic [7:0] opCode = 8'h00;
  logic coreClkEn, oscEnable, ramRetainOnly, interrupts_enabled_state;
  logic interrupts_disabled_state, intVectorReq, forceResetVector;
  logic halted, stopped, resetTooShort;
  int err_count = 0, compares = 0;
  // rows: enable, opcode, halts, vector
  logic [10:0] rows [3] = '{11'h407, 11'h006, 11'h008};
  always #5 clk = ~clk;
  hspc_seq_model i_seq (.*);
  hspc_power_ctrl #(.MC_CYCLES(8'h03)) i_dut (.*);
  // one comparison
  task automatic chk(input string n, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // halt, wake, vector per row; then reset and stop
  initial begin
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      @(posedge clk) enableIntOp <= rows[i][10];
      disableIntOp <= !rows[i][10];
      @(posedge clk) {enableIntOp, disableIntOp, opValid} <= 3'h1;
      opCode <= rows[i][9:2];
      @(posedge clk) opValid <= 1'b0;
      #1 chk("halted", rows[i][1], halted);
      chk("coreClkEn", !rows[i][1], coreClkEn);
      chk("intsOn", rows[i][10], interrupts_enabled_state);
      repeat (4) @(posedge clk);
      #1 chk("halted", rows[i][1], halted);
      chk("oscEnable", 1'b1, oscEnable);
      @(posedge clk) intReq_n <= 1'b0;
      @(posedge clk) intReq_n <= 1'b1;
      #1 chk("halted", 1'b0, halted);
      @(posedge clk) instrDone <= 1'b1;
      @(posedge clk) instrDone <= 1'b0;
      #1 chk("intVectorReq", 1'b0, intVectorReq);
      @(posedge clk) #1 chk("intVectorReq", rows[i][0], intVectorReq);
      @(posedge clk) vectorTaken <= 1'b1;
      @(posedge clk) vectorTaken <= 1'b0;
      $display("row %0d done", i);
    end
    @(posedge clk) {opValid, opCode} <= 9'h101;
    @(posedge clk) opValid <= 1'b0;
    i_seq.pulse_reset(20);
    #1 chk("forceResetVector", 1'b1, forceResetVector);
    chk("intsOff", 1'b1, interrupts_disabled_state);
    chk("halted", 1'b0, halted);
    $display("halt reset done");
    i_seq.enter_stop();
    repeat (2) @(posedge clk);
    #1 chk("stopped", 1'b1, stopped);
    chk("ramRetainOnly", 1'b1, ramRetainOnly);
    i_seq.leave_stop(20);
    #1 chk("oscEnable", 1'b1, oscEnable);
    repeat (2) @(posedge clk);
    #1 chk("coreClkEn", 1'b1, coreClkEn);
    chk("forceResetVector", 1'b0, forceResetVector);
    chk("stopped", 1'b0, stopped);
    chk("resetTooShort", 1'b0, resetTooShort);
    $display("stop done");
    i_seq.pulse_reset(6);
    repeat (2) @(posedge clk);
    #1 chk("resetTooShort", 1'b1, resetTooShort);
    $display("short reset done");
    finish_test();
  end
endmodule // hspc_power_ctrl_tb
`default_nettype wire

//--- bench/hspc_seq_model.sv
// reset and standby sequencer model
`default_nettype none
module hspc_seq_model (
  input wire logic clk,
  output var logic reset_n,
  output var logic standbyCtrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // power-on reset for three cycles
  initial begin
    reset_n = 1'b0;
    standbyCtrl = 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
  end
  // plain reset of n cycles
  task automatic pulse_reset(input int n);
    @(posedge clk) reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  // reset first, then standby low
  task automatic enter_stop;
    @(posedge clk) reset_n <= 1'b0;
    @(posedge clk) standbyCtrl <= 1'b0;
  endtask
  // standby high, settle, then release
  task automatic leave_stop(input int settle);
    @(posedge clk) standbyCtrl <= 1'b1;
    repeat (settle) @(posedge clk);
    reset_n <= 1'b1;
  endtask
endmodule // hspc_seq_model
`default_nettype wire

//--- rtl/hspc_defs.vh
// constants for the halt/stop power control block
`ifndef HSPC_DEFS_VH
`define HSPC_DEFS_VH
`define HSPC_HALT_OPCODE 8'h01
`define HSPC_RESET_VECTOR 12'h000
`define HSPC_ADDR_W 12
`define HSPC_MIN_RESET_MC 4'h5
`define HSPC_MC_CYCLES 8'h0F
`define HSPC_ST_RUN 3'h0
`define HSPC_ST_HALT 3'h1
`define HSPC_ST_WAKE_EI 3'h2
`define HSPC_ST_STOP 3'h3
`define HSPC_ST_RESET 3'h4
`endif

//--- rtl/hspc_mc_divider.v
// machine-cycle enable divider on the free-running clock
`default_nettype none
module hspc_mc_divider #(
  parameter [7:0] DIV = 8'h0F
) (
  input wire clk,
  input wire reset_n,
  input wire run,
  output reg tick
);
  reg [7:0] count_q;
  // count clocks while the oscillator runs; one-cycle tick at wrap
  always @(posedge clk) begin
    if (!reset_n || !run) begin
      count_q <= 8'h00;
      tick <= 1'b0;
    end else if (count_q == DIV - 8'h01) begin
      count_q <= 8'h00;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // hspc_mc_divider
`default_nettype wire

//--- rtl/hspc_power_ctrl.v
// halt and stop power sequencing for the 8-bit controller core
// Functional notes
// - executing the halt opcode enters halt mode.
// - halt gates internal clocks, internal logic stays inactive.
// - oscillator keeps running during halt.
// - all registers and status are preserved through halt.
// - halt ends only on interrupt request or reset.
// - enabled interrupt restarts clocks, next instruction, then vector.
// - exactly one instruction completes before the vector is taken.
// - disabled interrupt wakes and resumes sequentially, no service.
// - reset during halt resets normally, starts at address zero.
// - standby low while reset low enters stop mode.
// - stop halts oscillator; only RAM retained.
// - standby high while reset low leaves stop, oscillator restarts.
// - reset released after oscillator settles; execution from zero.
// - interrupt input active low; reset leaves interrupts disabled.
`default_nettype none
`include "hspc_defs.vh"
module hspc_power_ctrl #(
  parameter [7:0] MC_CYCLES = `HSPC_MC_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire standbyCtrl,
  input wire intReq_n,
  input wire opValid,
  input wire [7:0] opCode,
  input wire instrDone,
  input wire enableIntOp,
  input wire disableIntOp,
  input wire vectorTaken,
  output reg coreClkEn,
  output reg oscEnable,
  output reg ramRetainOnly,
  output reg interrupts_enabled_state,
  output reg interrupts_disabled_state,
  output reg intVectorReq,
  output reg forceResetVector,
  output reg halted,
  output reg stopped,
  output reg resetTooShort
);
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg intEn_q;
  reg oneInstrDone_q;
  reg [3:0] resetMc_q;
  wire mcTick;
  wire intActive;
  wire countClear_n;

  ////////////////////////////////////////////////////////////////////
  // true when an executed opcode is the halt instruction
  function isHaltOp;
    input valid;
    input [7:0] code;
    begin
      isHaltOp = valid && (code == `HSPC_HALT_OPCODE);
    end
  endfunction

  // true for the two states that stand for a reset in progress
  function inResetState;
    input [2:0] st;
    begin
      inResetState = (st == `HSPC_ST_STOP) || (st == `HSPC_ST_RESET);
    end
  endfunction

  // true for a state that keeps the core clocks gated
  function gatesCore;
    input [2:0] st;
    begin
      gatesCore = (st == `HSPC_ST_HALT);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // machine-cycle timebase, counts only while reset is held and the
  // oscillator runs; cleared whenever reset is released, so every
  // reset pulse is measured from zero
  assign countClear_n = !reset_n;

  hspc_mc_divider #(
    .DIV(MC_CYCLES)
  ) u_mc_div (
    .clk(clk),
    .reset_n(countClear_n),
    .run(oscEnable),
    .tick(mcTick)
  );

  // active-low request, pins are synchronous to clk
  assign intActive = !intReq_n;

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always @* begin
    state_d = state_q;
    case (state_q)
      `HSPC_ST_RUN: begin
        // halt only starts from run; other states ignore the opcode
        if (isHaltOp(opValid, opCode))
          state_d = `HSPC_ST_HALT;
      end
      `HSPC_ST_HALT: begin
        // only interrupt leaves halt here; reset handled below
        if (intActive && intEn_q)
          state_d = `HSPC_ST_WAKE_EI;
        else if (intActive)
          state_d = `HSPC_ST_RUN;
      end
      `HSPC_ST_WAKE_EI: begin
        if (instrDone)
          state_d = `HSPC_ST_RUN;
      end
      default: state_d = `HSPC_ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register with reset and stop sequencing
  always @(posedge clk) begin
    if (!reset_n) begin
      if (!standbyCtrl)
        state_q <= `HSPC_ST_STOP;
      else
        state_q <= `HSPC_ST_RESET;
    end else if (inResetState(state_q)) begin
      // one edge after release the core runs from address zero
      state_q <= `HSPC_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt enable, frozen in halt so state is kept
  // enable and disable ops only count while the core runs
  always @(posedge clk) begin
    if (!reset_n)
      intEn_q <= 1'b0;
    else if (state_q == `HSPC_ST_RUN && enableIntOp)
      intEn_q <= 1'b1;
    else if (state_q == `HSPC_ST_RUN && disableIntOp)
      intEn_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // vector request after the one post-halt instruction
  // set is tested first, so it wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!reset_n) begin
      oneInstrDone_q <= 1'b0;
      intVectorReq <= 1'b0;
    end else begin
      oneInstrDone_q <= state_q == `HSPC_ST_WAKE_EI && instrDone;
      if (oneInstrDone_q)
        intVectorReq <= 1'b1;
      else if (vectorTaken)
        intVectorReq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset width check in machine cycles
  always @(posedge clk) begin
    if (reset_n) begin
      resetMc_q <= 4'h0;
    end else if (mcTick && resetMc_q != 4'hF) begin
      resetMc_q <= resetMc_q + 4'h1;
    end
  end

  // judged at the first edge after release while the count stands;
  // sticky until the next reset begins
  always @(posedge clk) begin
    if (!reset_n)
      resetTooShort <= 1'b0;
    else if (state_q == `HSPC_ST_RESET && standbyCtrl &&
             resetMc_q < `HSPC_MIN_RESET_MC)
      resetTooShort <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // clock gating and oscillator; oscillator follows standby in reset
  always @(posedge clk) begin
    if (!reset_n) begin
      coreClkEn <= 1'b0;
      oscEnable <= standbyCtrl;
    end else begin
      // gate from next state so halt and the gate start together
      coreClkEn <= !gatesCore(state_d);
      oscEnable <= 1'b1;
    end
  end

  // status flags: stop, halt and restart from address zero
  always @(posedge clk) begin
    if (!reset_n) begin
      ramRetainOnly <= !standbyCtrl;
      forceResetVector <= 1'b1;
      halted <= 1'b0;
      stopped <= !standbyCtrl;
    end else begin
      ramRetainOnly <= 1'b0;
      forceResetVector <= 1'b0;
      halted <= gatesCore(state_d);
      stopped <= 1'b0;
    end
  end

  // interrupt enable mirrored on the two complementary outputs
  always @(posedge clk) begin
    if (!reset_n) begin
      interrupts_enabled_state <= 1'b0;
      interrupts_disabled_state <= 1'b1;
    end else begin
      interrupts_enabled_state <= intEn_q;
      interrupts_disabled_state <= !intEn_q;
    end
  end
endmodule // hspc_power_ctrl
`default_nettype wire
